// ===== afe_pkg.sv
// package: register map, field positions and timing constants for the afe timing block
`default_nettype none
package afe_pkg;
   // register addresses (6-bit)
   localparam logic [5:0] ADDR_SETUP_ONE = 6'h01;
   localparam logic [5:0] ADDR_SETUP_TWO = 6'h02;
   localparam logic [5:0] ADDR_SETUP_THREE = 6'h03;
   localparam logic [5:0] ADDR_SOFT_RESET = 6'h04;
   localparam logic [5:0] ADDR_SETUP_FOUR = 6'h06;
   localparam logic [5:0] ADDR_REVISION_ID = 6'h07;
   localparam logic [5:0] ADDR_STROBE_DETECT = 6'h08;
   localparam logic [5:0] ADDR_TEST_ONE = 6'h09;
   localparam logic [5:0] ADDR_RESERVED_A = 6'h0a;
   localparam logic [5:0] ADDR_RESERVED_B = 6'h0b;
   localparam logic [5:0] ADDR_RESERVED_C = 6'h0c;
   localparam logic [5:0] ADDR_OFFSET_RED = 6'h20;
   localparam logic [5:0] ADDR_OFFSET_GREEN = 6'h21;
   localparam logic [5:0] ADDR_OFFSET_BLUE = 6'h22;
   localparam logic [5:0] ADDR_OFFSET_ALL = 6'h23;
   localparam logic [5:0] ADDR_GAIN_RED = 6'h28;
   localparam logic [5:0] ADDR_GAIN_GREEN = 6'h29;
   localparam logic [5:0] ADDR_GAIN_BLUE = 6'h2a;
   localparam logic [5:0] ADDR_GAIN_ALL = 6'h2b;
   // reset values
   localparam logic [7:0] RST_SETUP_ONE = 8'h0f;
   localparam logic [7:0] RST_SETUP_TWO = 8'h23;
   localparam logic [7:0] RST_SETUP_THREE = 8'h1f;
   localparam logic [7:0] RST_SETUP_FOUR = 8'h05;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h80;
   localparam logic [7:0] RST_GAIN = 8'h00;
   // arbitrary neutral identification value
   localparam logic [7:0] REVISION_VALUE = 8'h5a;
   // field positions
   localparam int POWER_ENABLE_BIT = 0;
   localparam int CORRELATED_BIT = 1;
   localparam int FASTEST_MODE_BIT = 6;
   localparam int LATENCY_LSB = 6;
   localparam int DETECT_ENABLE_BIT = 0;
   localparam int DETECT_DELAY_LSB = 1;
   localparam int EDGE_SELECT_BIT = 4;
   // timing
   localparam int MCLK_PER_ADC = 2;
   localparam int MCLK_PER_ADC_MODE2 = 3;
   localparam int NIBBLES = 4;
   localparam int BASE_LATENCY = 1;
   // host-side recommended setup values
   localparam logic [7:0] SETUP_MODE1_CDS = 8'h0f;
   localparam logic [7:0] SETUP_MODE1_NOCDS = 8'h0d;
   localparam logic [7:0] SETUP_FASTEST_MODE_SELECT = 8'h4d;
endpackage
`default_nettype wire

// ===== afe_if.sv
// interface: strobe, register write port and nibble output between controller and front end
`default_nettype none
interface afe_if;
   logic pixel_sample_strobe;
   logic reg_write;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [3:0] nibble_output;
   logic nibble_valid;
   logic [15:0] sample_data;
   logic sample_taken;
   modport device (input pixel_sample_strobe, reg_write, reg_addr, reg_wdata,
      sample_data, output reg_rdata, nibble_output, nibble_valid, sample_taken);
   modport host (output pixel_sample_strobe, reg_write, reg_addr, reg_wdata,
      sample_data, input reg_rdata, nibble_output, nibble_valid, sample_taken);
endinterface
`default_nettype wire

// ===== afe_device.sv
// device end: register bank, strobe detect, sample timing and nibble output
`default_nettype none
module afe_device
   import afe_pkg::*;
#(
   parameter int DELAY_W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link to controller
   afe_if.device link,
   // mode 2 selection (latency unit of three periods)
   input wire logic mode_two,
   // user side: one-clock pulse for each sample taken
   output logic sample_strobe_int
);
   import afe_pkg::*;

   // register file
   logic [7:0] setup_one, setup_two, setup_three, setup_four, strobe_detect_setup, test_one;
   logic [7:0] reserved_a, reserved_b, reserved_c;
   logic [7:0] offset_red, offset_green, offset_blue;
   logic [7:0] gain_red, gain_green, gain_blue;
   logic [7:0] reg_rdata;
   // strobe synchroniser and edge logic
   logic strobe_meta, strobe_sync, strobe_prev;
   localparam int LINE_W = (1 << DELAY_W) - 1; // one stage per clock of the longest delay
   logic [LINE_W-1:0] edge_line; // detected edges, aged one clock per stage
   logic int_pulse, int_pulse_prev, pin_prev;
   logic take_sample;
   // output pipeline; deep enough for four adc periods of three clocks
   localparam int PIPE_DEPTH = (BASE_LATENCY + 3) * MCLK_PER_ADC_MODE2 + 1;
   logic [15:0] pipe_data [PIPE_DEPTH]; // captured samples, aged one clock per entry
   logic pipe_valid [PIPE_DEPTH];
   logic [3:0] lat_tap; // entry whose age matches the programmed latency
   logic [15:0] result;
   logic [1:0] nibble_idx;
   logic shifting;
   logic [3:0] nibble_output;
   logic nibble_valid;

   wire powered = setup_one[POWER_ENABLE_BIT];
   wire detect_on = strobe_detect_setup[DETECT_ENABLE_BIT];
   wire edge_rise = strobe_detect_setup[EDGE_SELECT_BIT];
   wire [DELAY_W-1:0] delay_val = strobe_detect_setup[DETECT_DELAY_LSB +: DELAY_W];
   // chosen edge on the synchronised strobe
   wire edge_hit = detect_on && powered &&
      (edge_rise ? (strobe_sync && !strobe_prev) : (!strobe_sync && strobe_prev));
   // one adc period is two clocks, three in mode 2
   assign lat_tap = 4'((BASE_LATENCY + int'(setup_two[LATENCY_LSB +: 2]))
                       * (mode_two ? MCLK_PER_ADC_MODE2 : MCLK_PER_ADC));

   // register writes; soft reset restores defaults, power-down keeps values
   always_ff @(posedge clk) begin
      if (!rst_n || (link.reg_write && link.reg_addr == ADDR_SOFT_RESET)) begin
         setup_one <= RST_SETUP_ONE;
         setup_two <= RST_SETUP_TWO;
         setup_three <= RST_SETUP_THREE;
         setup_four <= RST_SETUP_FOUR;
         strobe_detect_setup <= RST_ZERO;
         test_one <= RST_ZERO;
         reserved_a <= RST_ZERO;
         reserved_b <= RST_ZERO;
         reserved_c <= RST_ZERO;
         offset_red <= RST_OFFSET;
         offset_green <= RST_OFFSET;
         offset_blue <= RST_OFFSET;
         gain_red <= RST_GAIN;
         gain_green <= RST_GAIN;
         gain_blue <= RST_GAIN;
      end else if (link.reg_write) begin
         case (link.reg_addr)
            ADDR_SETUP_ONE: setup_one <= link.reg_wdata;
            ADDR_SETUP_TWO: setup_two <= link.reg_wdata;
            ADDR_SETUP_THREE: setup_three <= link.reg_wdata;
            ADDR_SETUP_FOUR: setup_four <= link.reg_wdata;
            ADDR_STROBE_DETECT: strobe_detect_setup <= link.reg_wdata;
            ADDR_TEST_ONE: test_one <= link.reg_wdata;
            ADDR_RESERVED_A: reserved_a <= link.reg_wdata;
            ADDR_RESERVED_B: reserved_b <= link.reg_wdata;
            ADDR_RESERVED_C: reserved_c <= link.reg_wdata;
            ADDR_OFFSET_RED: offset_red <= link.reg_wdata;
            ADDR_OFFSET_GREEN: offset_green <= link.reg_wdata;
            ADDR_OFFSET_BLUE: offset_blue <= link.reg_wdata;
            ADDR_OFFSET_ALL: begin
               offset_red <= link.reg_wdata;
               offset_green <= link.reg_wdata;
               offset_blue <= link.reg_wdata;
            end
            ADDR_GAIN_RED: gain_red <= link.reg_wdata;
            ADDR_GAIN_GREEN: gain_green <= link.reg_wdata;
            ADDR_GAIN_BLUE: gain_blue <= link.reg_wdata;
            ADDR_GAIN_ALL: begin
               gain_red <= link.reg_wdata;
               gain_green <= link.reg_wdata;
               gain_blue <= link.reg_wdata;
            end
            default: ; // revision and unmapped writes are ignored
         endcase
      end
   end

   // registered read-back of the addressed register; write-only ones read zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= RST_ZERO;
      end else begin
         case (link.reg_addr)
            ADDR_SETUP_ONE: reg_rdata <= setup_one;
            ADDR_SETUP_TWO: reg_rdata <= setup_two;
            ADDR_SETUP_THREE: reg_rdata <= setup_three;
            ADDR_SETUP_FOUR: reg_rdata <= setup_four;
            ADDR_REVISION_ID: reg_rdata <= REVISION_VALUE;
            ADDR_STROBE_DETECT: reg_rdata <= strobe_detect_setup;
            ADDR_TEST_ONE: reg_rdata <= test_one;
            ADDR_RESERVED_A: reg_rdata <= reserved_a;
            ADDR_RESERVED_B: reg_rdata <= reserved_b;
            ADDR_RESERVED_C: reg_rdata <= reserved_c;
            ADDR_OFFSET_RED: reg_rdata <= offset_red;
            ADDR_OFFSET_GREEN: reg_rdata <= offset_green;
            ADDR_OFFSET_BLUE: reg_rdata <= offset_blue;
            ADDR_GAIN_RED: reg_rdata <= gain_red;
            ADDR_GAIN_GREEN: reg_rdata <= gain_green;
            ADDR_GAIN_BLUE: reg_rdata <= gain_blue;
            default: reg_rdata <= RST_ZERO;
         endcase
      end
   end
   assign link.reg_rdata = reg_rdata;

   // two-flop synchroniser on the strobe pin; the first flop feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
         strobe_prev <= 1'b0;
      end else begin
         strobe_meta <= link.pixel_sample_strobe;
         strobe_sync <= strobe_meta;
         strobe_prev <= strobe_sync;
      end
   end

   // edge detect with optional delay; a delay line rather than a counter, so edges
   // that come closer together than the delay are all kept
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edge_line <= '0;
         int_pulse <= 1'b0;
      end else begin
         edge_line <= {edge_line[LINE_W-2:0], edge_hit};
         if (delay_val == '0) begin
            int_pulse <= edge_hit;
         end else begin
            int_pulse <= edge_line[delay_val - DELAY_W'(1)];
         end
      end
   end

   // sample on the edge after the strobe (pin or internal) goes low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         int_pulse_prev <= 1'b0;
         pin_prev <= 1'b0;
         take_sample <= 1'b0;
      end else begin
         int_pulse_prev <= int_pulse;
         pin_prev <= strobe_sync;
         // same timing whether correlated sampling is on or off
         take_sample <= powered && (detect_on ? (int_pulse_prev && !int_pulse)
                                              : (pin_prev && !strobe_sync));
      end
   end

   // stage zero takes the sample at its sampling instant
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pipe_valid[0] <= 1'b0;
         pipe_data[0] <= '0;
      end else begin
         pipe_valid[0] <= take_sample;
         pipe_data[0] <= link.sample_data;
      end
   end

   // later entries age one clock each, so a latency longer than the pixel period is fine
   for (genvar g = 1; g < PIPE_DEPTH; g++) begin : g_pipe
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            pipe_valid[g] <= 1'b0;
            pipe_data[g] <= '0;
         end else begin
            pipe_valid[g] <= pipe_valid[g - 1];
            pipe_data[g] <= pipe_data[g - 1];
         end
      end
   end

   // four nibbles, most significant first, from the clock the tapped entry arrives;
   // an arrival within three clocks of the last one cuts the running burst short
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result <= '0;
         nibble_idx <= '0;
         shifting <= 1'b0;
         nibble_output <= 4'h0;
         nibble_valid <= 1'b0;
         sample_strobe_int <= 1'b0;
      end else begin
         sample_strobe_int <= take_sample;
         nibble_valid <= 1'b0;
         if (pipe_valid[lat_tap]) begin
            result <= pipe_data[lat_tap];
            nibble_output <= pipe_data[lat_tap][15:12];
            nibble_valid <= 1'b1;
            nibble_idx <= 2'h1;
            shifting <= 1'b1;
         end else if (shifting) begin
            nibble_output <= result[15 - 4 * int'(nibble_idx) -: 4];
            nibble_valid <= 1'b1;
            nibble_idx <= nibble_idx + 2'h1;
            if (nibble_idx == 2'(NIBBLES - 1)) begin
               shifting <= 1'b0;
            end
         end
      end
   end
   assign link.nibble_output = nibble_output;
   assign link.nibble_valid = nibble_valid;
   assign link.sample_taken = sample_strobe_int;
endmodule
`default_nettype wire

// ===== afe_host.sv
// host end: strobe generator and register write sequencer
`default_nettype none
module afe_host
   import afe_pkg::*;
#(
   parameter int RATIO = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link to front end
   afe_if.host link,
   // user side: register write request and data, sample value, strobe enable, read-back and nibble outputs
   input wire logic wr_req,
   input wire logic [5:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [15:0] user_sample,
   input wire logic strobe_run,
   output logic [7:0] rd_data,
   output logic [3:0] nib_out,
   output logic nib_valid
);
   import afe_pkg::*;

   logic [7:0] ratio_cnt; // master periods within one pixel
   logic strobe;
   logic wr_q;
   logic [5:0] addr_q;
   logic [7:0] data_q;

   // one-period strobe once per pixel at the chosen clock ratio
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ratio_cnt <= '0;
         strobe <= 1'b0;
      end else if (strobe_run) begin
         strobe <= (ratio_cnt == 8'h00);
         ratio_cnt <= (ratio_cnt == 8'(RATIO - 1)) ? 8'h00 : ratio_cnt + 8'h01;
      end else begin
         strobe <= 1'b0;
         ratio_cnt <= '0;
      end
   end

   // register write sequencer: user supplies values such as the mode setups
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
         addr_q <= '0;
         data_q <= '0;
      end else begin
         wr_q <= wr_req;
         addr_q <= wr_addr;
         data_q <= wr_data;
      end
   end

   // capture read-back and nibble stream
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= '0;
         nib_out <= '0;
         nib_valid <= 1'b0;
      end else begin
         rd_data <= link.reg_rdata;
         nib_out <= link.nibble_output;
         nib_valid <= link.nibble_valid;
      end
   end

   assign link.pixel_sample_strobe = strobe;
   assign link.reg_write = wr_q;
   assign link.reg_addr = addr_q;
   assign link.reg_wdata = data_q;
   assign link.sample_data = user_sample;
endmodule
`default_nettype wire

// ===== afe_link_assertions.sv
// checker: timing and register relations seen on the link between the two ends
`default_nettype none
module afe_link_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link signals
   input wire logic pixel_sample_strobe,
   input wire logic reg_write,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [3:0] nibble_output,
   input wire logic nibble_valid,
   input wire logic [15:0] sample_data,
   input wire logic sample_taken
);
   timeunit 1ns;
   timeprecision 100ps;
   import afe_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic en; // shadow of power enable
   logic det; // shadow of detect enable
   logic [7:0] red; // shadow of red gain
   logic [3:0] off_cnt; // cycles spent powered down
   logic [15:0] cap; // result held from its sampling instant
   wire wr_soft = reg_write && reg_addr == ADDR_SOFT_RESET;
   // sampling controls; a soft reset brings back the defaults
   always_ff @(posedge clk) begin
      if (!rst_n || wr_soft) begin
         en <= 1'b1;
         det <= 1'b0;
      end else if (reg_write && reg_addr == ADDR_SETUP_ONE) begin
         en <= reg_wdata[POWER_ENABLE_BIT];
      end else if (reg_write && reg_addr == ADDR_STROBE_DETECT) begin
         det <= reg_wdata[DETECT_ENABLE_BIT];
      end
   end
   // red gain is loaded by its own address and by the all-colour one
   always_ff @(posedge clk) begin
      if (!rst_n || wr_soft) begin
         red <= RST_GAIN;
      end else if (reg_write && (reg_addr == ADDR_GAIN_RED || reg_addr == ADDR_GAIN_ALL)) begin
         red <= reg_wdata;
      end
   end
   // saturating, so a long power-down never wraps back to zero
   always_ff @(posedge clk) begin
      if (!rst_n || en) begin
         off_cnt <= 4'h0;
      end else if (off_cnt != 4'hf) begin
         off_cnt <= off_cnt + 4'h1;
      end
   end
   // capture the result when a sample is taken
   always_ff @(posedge clk) begin
      if (sample_taken) begin
         cap <= sample_data;
      end
   end
   sequence nib_burst;
      nibble_output == cap[15:12] ##1 nibble_output == cap[11:8]
      ##1 nibble_output == cap[7:4] ##1 nibble_output == cap[3:0];
   endsequence
   a_take_after_fall:
      assert property (en && !det && $fell(pixel_sample_strobe) |-> ##[2:5] sample_taken)
      else $error("no sample after strobe fall");
   a_quiet_when_off:
      assert property (off_cnt > 4'h7 |-> !sample_taken) else $error("sample while off");
   a_taken_is_pulse:
      assert property (sample_taken |=> !sample_taken) else $error("sample pulse too long");
   a_revision_fixed:
      assert property ((reg_addr == ADDR_REVISION_ID)[*2] |-> reg_rdata == REVISION_VALUE)
      else $error("revision value wrong");
   a_write_lands:
      assert property (reg_write && reg_addr == ADDR_SETUP_TWO ##1
         (!reg_write && $stable(reg_addr))[*2] |-> reg_rdata == $past(reg_wdata, 2))
      else $error("write not applied");
   a_red_shadow:
      assert property ((reg_addr == ADDR_GAIN_RED && !reg_write)[*2] |-> reg_rdata == $past(red))
      else $error("red gain wrong");
   a_nibble_run:
      assert property ($rose(nibble_valid) |-> nibble_valid[*4] ##1 !nibble_valid)
      else $error("nibble burst length wrong");
   a_msb_first:
      assert property ($rose(nibble_valid) |-> nib_burst) else $error("nibble order wrong");
   a_result_follows:
      assert property (sample_taken |-> ##[1:30] $rose(nibble_valid))
      else $error("result never output");
endmodule
`default_nettype wire

// ===== afe_sample_timing_and_config_bench.sv
// testbench: host and front end joined by the link, driven from the host user side
`default_nettype none
module afe_sample_timing_and_config_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import afe_pkg::*;
   typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} afe_row_t;
   logic clk;
   logic rst_n;
   logic wr_req;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic [15:0] user_sample;
   logic strobe_run;
   logic mode_two; // selects three clocks per adc period
   logic [7:0] rd_data;
   logic [3:0] nib_out;
   logic nib_valid;
   logic taken_int; // device pulse per sample
   int n_mismatch;
   int comparisons;
   int n_taken; // samples seen on the link
   int cycles; // watchdog count
   // write flag, address, data, value expected on read
   afe_row_t rows [15] = '{
      '{1'b0, ADDR_SETUP_ONE, 8'h00, RST_SETUP_ONE}, '{1'b0, ADDR_SETUP_TWO, 8'h00, RST_SETUP_TWO},
      '{1'b0, ADDR_SETUP_THREE, 8'h00, RST_SETUP_THREE},
      '{1'b0, ADDR_SETUP_FOUR, 8'h00, RST_SETUP_FOUR},
      '{1'b0, ADDR_OFFSET_RED, 8'h00, RST_OFFSET}, '{1'b0, ADDR_STROBE_DETECT, 8'h00, RST_ZERO},
      '{1'b1, ADDR_SETUP_TWO, 8'h63, 8'h63}, '{1'b1, ADDR_OFFSET_BLUE, 8'h44, 8'h44},
      '{1'b1, ADDR_REVISION_ID, 8'h12, REVISION_VALUE}, '{1'b1, ADDR_GAIN_ALL, 8'h3c, 8'h00},
      '{1'b0, ADDR_GAIN_RED, 8'h00, 8'h3c}, '{1'b0, ADDR_GAIN_BLUE, 8'h00, 8'h3c},
      '{1'b1, ADDR_OFFSET_ALL, 8'h11, 8'h00}, '{1'b0, ADDR_OFFSET_GREEN, 8'h00, 8'h11},
      '{1'b1, ADDR_TEST_ONE, 8'h80, 8'h80}};
   afe_if link ();
   afe_host i_afe_host (.clk(clk), .rst_n(rst_n), .link(link.host), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .user_sample(user_sample),
      .strobe_run(strobe_run), .rd_data(rd_data), .nib_out(nib_out), .nib_valid(nib_valid));
   afe_device i_afe_device (.clk(clk), .rst_n(rst_n), .link(link.device), .mode_two(mode_two),
      .sample_strobe_int(taken_int));
   afe_link_assertions i_afe_link_assertions (.clk(clk), .rst_n(rst_n),
      .pixel_sample_strobe(link.pixel_sample_strobe), .reg_write(link.reg_write),
      .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .nibble_output(link.nibble_output), .nibble_valid(link.nibble_valid),
      .sample_data(link.sample_data), .sample_taken(link.sample_taken));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // count samples; the ceiling is far above the several hundred cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (taken_int === 1'b1) begin
         n_taken <= n_taken + 1;
      end
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one register write; the address stays put afterwards
   task automatic put(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 wr_req = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(posedge clk);
      #1 wr_req = 1'b0;
   endtask
   // read back: address held until the registered answer has settled
   task automatic get(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 wr_addr = a;
      repeat (5) @(posedge clk);
      #1 d = rd_data;
   endtask
   // run the strobe until the first result is out, then compare it and its delay
   task automatic run_sample(input logic [15:0] s, input int lat);
      logic [15:0] r;
      int k;
      k = 0;
      @(posedge clk);
      #1 user_sample = s;
      strobe_run = 1'b1;
      while (nib_valid !== 1'b1 && k < 80) begin
         @(posedge clk);
         #1 k++;
      end
      for (int i = 0; i < 4; i++) begin
         r = {r[11:0], nib_out};
         @(posedge clk);
         #1;
      end
      strobe_run = 1'b0;
      repeat (40) @(posedge clk);
      check("result", r, s);
      check("latency", 16'(k), 16'(lat));
   endtask
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      logic [7:0] v;
      int n0;
      rst_n = 1'b0;
      wr_req = 1'b0;
      wr_addr = 6'h00;
      wr_data = 8'h00;
      user_sample = 16'h0000;
      strobe_run = 1'b0;
      mode_two = 1'b0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            put(rows[i].a, rows[i].d);
         end
         get(rows[i].a, v);
         check($sformatf("reg %h", rows[i].a), {8'h00, v}, {8'h00, rows[i].e});
      end
      // soft reset undoes earlier writes
      put(ADDR_SOFT_RESET, 8'h5f);
      get(ADDR_SETUP_TWO, v);
      check("setup_two", {8'h00, v}, {8'h00, RST_SETUP_TWO});
      get(ADDR_GAIN_RED, v);
      check("gain_red", {8'h00, v}, {8'h00, RST_GAIN});
      // pin strobe: eight clocks of sync, sampling and capture, then the latency
      run_sample(16'ha5c3, 8 + BASE_LATENCY * MCLK_PER_ADC);
      // longest latency, then power down with the strobe running
      put(ADDR_SETUP_TWO, 8'he3);
      put(ADDR_SETUP_ONE, 8'h0e);
      n0 = n_taken;
      strobe_run = 1'b1;
      repeat (60) @(posedge clk);
      #1 strobe_run = 1'b0;
      check("samples off", 16'(n_taken - n0), 16'h0000);
      put(ADDR_OFFSET_GREEN, 8'h3a);
      get(ADDR_OFFSET_GREEN, v);
      check("offset_green", {8'h00, v}, 16'h003a);
      get(ADDR_SETUP_TWO, v);
      check("setup_two kept", {8'h00, v}, 16'h00e3);
      // power back on without correlated sampling: timing must not move
      put(ADDR_SETUP_ONE, SETUP_MODE1_NOCDS);
      run_sample(16'h1e7b, 8 + (BASE_LATENCY + 3) * MCLK_PER_ADC);
      // edge detect: falling edge no delay, rising edge longest delay
      put(ADDR_STROBE_DETECT, 8'h01);
      run_sample(16'h0ff0, 10 + (BASE_LATENCY + 3) * MCLK_PER_ADC);
      put(ADDR_STROBE_DETECT, 8'h1f);
      // a rising edge is seen one clock before the fall, then waits seven more
      run_sample(16'hc396, 9 + 7 + (BASE_LATENCY + 3) * MCLK_PER_ADC);
      // mode 2: three clocks per adc period, pin strobe again
      put(ADDR_STROBE_DETECT, RST_ZERO);
      mode_two = 1'b1;
      run_sample(16'h6b2d, 8 + (BASE_LATENCY + 3) * MCLK_PER_ADC_MODE2);
      give_verdict();
   end
endmodule
`default_nettype wire
